// [rtl/adc_conv_device.sv]
// Converter end of the serial link: frame counting, sampler control,
// result shifting and three-state control, plus a system-side result port.
// Assumes the host runs the serial clock freely and holds the frame
// select high for at least two serial periods between frames.
`timescale 1ns/10ps

// Contract
// - Frame fall: hold, sample, convert, drive out
// - Serial clock is the conversion clock
// - Wide variant needs sixteen clocks per frame
// - Narrow variant completes after fourteen clocks
// - After thirteen falls, track on next rise
// - Wide variant releases output at sixteenth fall
// - Wide variant: early frame end aborts, releases
// - Narrow variant: early frame end aborts, releases
// - Narrow variant in long frame releases at sixteenth
// - Narrow variant sends two trailing zeros
// - Frame fall shows zero, falls shift next
// - Last bit launched fifteenth, valid sixteenth fall
// - Rising-edge host misses first zero
// - Rising-edge host takes last bit fifteenth rise
// - Frame fall after clock fall still works
// - Host uses eight-clock burst for power-down
// - Host masters clock, spaces frames equally
module adc_conv_device #(
    parameter int RESOLUTION = adc_link_pkg::FULL_RES
) (
    adc_link_if.device                link,
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset,
    input  wire logic [RESOLUTION-1:0] i_analog_code,
    output logic      [RESOLUTION-1:0] o_result,
    output logic                      o_result_valid,
    output logic                      o_sampler_hold
);

    // Clocks of serial clock that complete a conversion
    localparam adc_link_pkg::count_t CONV_CLKS =
        adc_link_pkg::count_t'(RESOLUTION + adc_link_pkg::HEADER_BITS);
    // Zero bits below the result in the frame word
    localparam int PAD_BITS =
        adc_link_pkg::WORD_BITS - adc_link_pkg::HEADER_BITS - RESOLUTION;

    // Frame state, cleared while the frame select is high
    typedef struct packed {
        adc_link_pkg::count_t  count;  // Serial falls seen this frame
        logic [RESOLUTION-1:0] code;   // Sampled conversion value
        adc_link_pkg::word_t   shreg;  // Bits still to be sent
        logic                  dout;   // Bit on the result line
    } frame_t;

    // Link-clock state that outlives a frame
    typedef struct packed {
        logic [RESOLUTION-1:0] code_s1;     // Analog input, first stage
        logic [RESOLUTION-1:0] code_s2;     // Analog input, second stage
        logic [RESOLUTION-1:0] result_hold; // Last completed result
        logic                  complete;    // Level: last frame completed
    } keep_t;

    // System-clock state
    typedef struct packed {
        logic                  hold_s1;  // Sampler level, first stage
        logic                  hold_s2;  // Sampler level, second stage
        logic                  done_s1;  // Completion level, first stage
        logic                  done_s2;  // Completion level, second stage
        logic                  done_s3;  // Previous completion level
        logic [RESOLUTION-1:0] result;   // Result for the user
        logic                  valid;    // One-cycle result strobe
        logic                  hold;     // Sampler state for the user
    } sys_t;

    frame_t frame;       // Frame registers
    frame_t next_frame;  // Their next value
    keep_t  keep;        // Persistent link registers
    keep_t  next_keep;   // Their next value
    sys_t   sys;         // System registers
    sys_t   next_sys;    // Their next value
    logic   track_back;  // Sampler returned to track this frame
    logic   sampler_hold; // Sampler is holding

    // Frame counting and shifting, on serial falling edges
    always_comb
    begin
        next_frame = frame;
        if (frame.count != adc_link_pkg::FULL_FRAME_CLKS)
        begin
            next_frame.count = frame.count + 5'h01;
        end
        if (frame.count == 5'h00)
        begin
            next_frame.code  = keep.code_s2;
            // First two header zeros already accounted for; the other two lead the word
            next_frame.shreg = adc_link_pkg::word_t'(keep.code_s2) << (PAD_BITS + 2);
            next_frame.dout  = 1'b0;
        end
        else
        begin
            next_frame.dout  = frame.shreg[adc_link_pkg::WORD_BITS-1];
            next_frame.shreg = frame.shreg << 1;
        end
    end

    // Frame select high acts as a clear; the frame starts from zero
    // Early frame end aborts
    always_ff @(negedge link.serial_clk or posedge link.frame_select_n)
    begin
        if (link.frame_select_n)
        begin
            frame <= '0;
        end
        else
        begin
            frame <= next_frame;
        end
    end

    // Input capture and completion tracking on serial falling edges
    always_comb
    begin
        next_keep         = keep;
        next_keep.code_s1 = i_analog_code;
        next_keep.code_s2 = keep.code_s1;
        if (link.frame_select_n)
        begin
            // Idle fall between frames
            next_keep.complete = 1'b0;
        end
        else if (frame.count == CONV_CLKS - 5'h01)
        begin
            next_keep.complete    = 1'b1;
            next_keep.result_hold = frame.code;
        end
    end

    // No clear here: the result must survive the frame end
    always_ff @(negedge link.serial_clk)
    begin
        keep <= next_keep;
    end

    // Sampler return to track, on rising edges
    always_ff @(posedge link.serial_clk or posedge link.frame_select_n)
    begin
        if (link.frame_select_n)
        begin
            track_back <= 1'b0;
        end
        else
        begin
            track_back <= (frame.count >= adc_link_pkg::TRACK_FALLS);
        end
    end

    assign sampler_hold = ~link.frame_select_n & ~track_back;

    // Result line and its enable
    // Last bit held to sixteenth
    assign link.result_out = frame.dout;
    assign link.result_oe  = ~link.frame_select_n &
                             (frame.count != adc_link_pkg::FULL_FRAME_CLKS);

    // System side: level synchronisers and result strobe
    always_comb
    begin
        next_sys         = sys;
        next_sys.hold_s1 = sampler_hold;
        next_sys.hold_s2 = sys.hold_s1;
        next_sys.hold    = sys.hold_s2;
        next_sys.done_s1 = keep.complete;
        next_sys.done_s2 = sys.done_s1;
        next_sys.done_s3 = sys.done_s2;
        next_sys.valid   = 1'b0;
        // Rising completion; held word is stable for a whole frame
        if (sys.done_s2 && !sys.done_s3)
        begin
            next_sys.result = keep.result_hold;
            next_sys.valid  = 1'b1;
        end
    end

    // System registers, synchronous reset
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            sys <= '0;
        end
        else
        begin
            sys <= next_sys;
        end
    end

    // Outputs straight from system flops
    assign o_result       = sys.result;
    assign o_result_valid = sys.valid;
    assign o_sampler_hold = sys.hold;

endmodule // adc_conv_device

// [rtl/adc_link_pkg.sv]
// Shared constants and types for the serial conversion link.
// Assumes both ends import nothing and use scoped names.
package adc_link_pkg;

    // Frame word length on the wire
    localparam int WORD_BITS   = 16;
    // Four leading zeros ahead of the result
    localparam int HEADER_BITS = 4;
    // Resolution of the wide variant
    localparam int FULL_RES    = 12;
    // Width of the falling-edge counter
    localparam int CNT_BITS    = 5;

    typedef logic [WORD_BITS-1:0] word_t;
    typedef logic [CNT_BITS-1:0]  count_t;

    // Falling edges in a full frame
    localparam count_t FULL_FRAME_CLKS = 5'h10;
    // Falling edges before the sampler returns to track
    localparam count_t TRACK_FALLS     = 5'h0d;
    // Falling edges in a power-down burst
    localparam count_t BURST_CLKS      = 5'h08;

    // Host divider width
    localparam int DIV_BITS     = 8;
    // System clocks per serial clock half period
    localparam int HALF_PERIOD  = 4;
    // Serial clock periods from one frame start to the next
    localparam int FRAME_PERIOD = 20;

    // Host frame sequencer states
    typedef enum logic [1:0] {
        H_IDLE,
        H_FRAME,
        H_CLOSE
    } host_state_t;

endpackage

// [rtl/adc_link_if.sv]
// Link between the converter port and its host serial master.
// Assumes the bench connects both ends to one instance.
`timescale 1ns/10ps
interface adc_link_if;

    logic frame_select_n;  // Active-low frame select, host driven
    logic serial_clk;      // Serial and conversion clock, host driven
    logic result_out;      // Result bit from the converter
    logic result_oe;       // Converter drives result line when high
    wire  result_line;     // Level seen on the shared result wire

    // Wire level worked out from the enable; a released line shows the inverse of
    // result_out, which is zero once released, so a late capture by the host reads a one
    assign result_line = result_oe ? result_out : ~result_out;

    // Converter end
    modport device (
        input  frame_select_n,
        input  serial_clk,
        output result_out,
        output result_oe
    );

    // Host end
    modport host (
        output frame_select_n,
        output serial_clk,
        input  result_line
    );

endinterface

// [rtl/adc_conv_host.sv]
// Host serial master: makes the serial clock, frames conversions at a
// fixed spacing and collects the sixteen-bit result word.
// Assumes the converter end shares the link interface.
`timescale 1ns/10ps
module adc_conv_host #(
    parameter int HALF_PERIOD  = adc_link_pkg::HALF_PERIOD,
    parameter int FRAME_PERIOD = adc_link_pkg::FRAME_PERIOD
) (
    adc_link_if.host                   link,
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_enable,
    input  wire logic                  i_power_down,
    output adc_link_pkg::word_t        o_word,
    output logic                       o_word_valid,
    output logic                       o_busy
);

    // Last divider count of a half period
    localparam logic [adc_link_pkg::DIV_BITS-1:0] HALF_LAST =
        adc_link_pkg::DIV_BITS'(HALF_PERIOD - 1);
    // Last slot of a frame period
    localparam logic [adc_link_pkg::DIV_BITS-1:0] SLOT_LAST =
        adc_link_pkg::DIV_BITS'(FRAME_PERIOD - 1);

    // Whole host state
    typedef struct packed {
        logic [adc_link_pkg::DIV_BITS-1:0] div;   // Half-period divider
        logic                         sclk;       // Serial clock level
        logic                         cs_n;       // Frame select level
        adc_link_pkg::host_state_t    state;      // Sequencer state
        logic [adc_link_pkg::DIV_BITS-1:0] slot;  // Period in frame slot
        adc_link_pkg::count_t         falls;      // Falls in this frame
        logic                         burst;      // Power-down burst frame
        logic                         line_s1;    // Result line, first stage
        logic                         line_s2;    // Result line, second stage
        adc_link_pkg::word_t          shreg;      // Bits gathered so far
        adc_link_pkg::word_t          word;       // Last full word
        logic                         valid;      // One-cycle word strobe
        logic                         busy;       // Frame in progress
    } host_t;

    host_t host;       // Registers
    host_t next_host;  // Their next value
    adc_link_pkg::count_t frame_len;  // Falls wanted this frame
    logic  half_end;   // Divider at end of a half period

    // Sequencer and clock maker
    always_comb
    begin
        next_host         = host;
        next_host.valid   = 1'b0;
        next_host.line_s1 = link.result_line;
        next_host.line_s2 = host.line_s1;
        frame_len = host.burst ? adc_link_pkg::BURST_CLKS
                               : adc_link_pkg::FULL_FRAME_CLKS;
        half_end  = (host.div == HALF_LAST);
        next_host.div = half_end ? '0 : host.div + 8'h01;
        if (half_end)
        begin
            next_host.sclk = ~host.sclk;
            if (host.sclk)
            begin
                // Falling edge: take the bit shown since the last one
                if (host.state == adc_link_pkg::H_FRAME)
                begin
                    next_host.shreg = {host.shreg[adc_link_pkg::WORD_BITS-2:0],
                                       host.line_s2};
                    next_host.falls = host.falls + 5'h01;
                    if (host.falls + 5'h01 == frame_len)
                    begin
                        next_host.state = adc_link_pkg::H_CLOSE;
                    end
                end
            end
            else
            begin
                // Rising edge: slot timing and frame select changes
                next_host.slot = (host.slot == SLOT_LAST) ? '0 : host.slot + 8'h01;
                case (host.state)
                    adc_link_pkg::H_IDLE:
                    begin
                        if (host.slot == SLOT_LAST && i_enable)
                        begin
                            next_host.state = adc_link_pkg::H_FRAME;
                            next_host.cs_n  = 1'b0;
                            next_host.falls = '0;
                            next_host.burst = i_power_down;
                        end
                    end
                    adc_link_pkg::H_FRAME:
                    begin
                        // Waiting for the last fall
                        next_host.cs_n = 1'b0;
                    end
                    adc_link_pkg::H_CLOSE:
                    begin
                        next_host.cs_n  = 1'b1;
                        next_host.state = adc_link_pkg::H_IDLE;
                        // Burst frames carry no result
                        if (!host.burst)
                        begin
                            next_host.word  = host.shreg;
                            next_host.valid = 1'b1;
                        end
                    end
                    default:
                    begin
                        next_host.state = adc_link_pkg::H_IDLE;
                        next_host.cs_n  = 1'b1;
                    end
                endcase
            end
        end
        next_host.busy = (next_host.state != adc_link_pkg::H_IDLE);
    end

    // Registers, synchronous reset; idle line is clock high, select high
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            host      <= '0;
            host.sclk <= 1'b1;
            host.cs_n <= 1'b1;
        end
        else
        begin
            host <= next_host;
        end
    end

    // Outputs straight from flops
    assign link.serial_clk     = host.sclk;
    assign link.frame_select_n = host.cs_n;
    assign o_word              = host.word;
    assign o_word_valid        = host.valid;
    assign o_busy              = host.busy;

endmodule // adc_conv_host

// [bench/adc_link_props.sv]
// Checker for the link between converter end and host end.
// Assumes the link signals plus system clock and reset as plain inputs.
`timescale 1ns/10ps
module adc_link_props (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic frame_select_n,
    input  wire logic serial_clk,
    input  wire logic result_out,
    input  wire logic result_oe
);
    // System clocks from one frame start to the next, minus one
    localparam int GAP = 159;

    logic       prev_clk;  // Serial clock one cycle ago
    logic       prev_sel;  // Frame select one cycle ago
    logic       started;   // A frame start was seen
    logic [4:0] fall_cnt;  // Serial falls so far in frame
    logic [8:0] gap_cnt;   // Cycles since last frame start
    logic       fall_now;  // Serial fall seen at this edge
    logic [4:0] seen;      // Falls including this edge

    assign fall_now = prev_clk & ~serial_clk;
    assign seen     = fall_cnt + {4'h0, fall_now};

    // Serial edges are seen from the system side, as the host makes them
    always_ff @(posedge i_sys_clk)
    begin
        prev_clk <= serial_clk;
        prev_sel <= frame_select_n;
        if (i_reset || frame_select_n)
            fall_cnt <= 5'h00;
        else if (fall_now && fall_cnt != 5'h1f)
            fall_cnt <= seen;
        // Spacing count restarts at each frame start
        if (i_reset)
        begin
            started <= 1'b0;
            gap_cnt <= 9'h000;
        end
        else if (prev_sel && !frame_select_n)
        begin
            started <= 1'b1;
            gap_cnt <= 9'h000;
        end
        else if (gap_cnt != 9'h1ff)
            gap_cnt <= gap_cnt + 9'h001;
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    drive_in_frame_a: assert property (
        !frame_select_n && seen < 5'h10 |-> result_oe)
        else $error("result line idle inside frame");
    release_at_16_a: assert property (
        !frame_select_n && seen == 5'h10 |-> !result_oe)
        else $error("result line driven after sixteenth fall");
    idle_release_a: assert property (
        frame_select_n |-> !result_oe)
        else $error("result line driven with select high");
    leading_zeros_a: assert property (
        !frame_select_n && seen < 5'h04 |-> !result_out)
        else $error("header bit not zero");
    bits_on_falls_a: assert property (
        !frame_select_n && $past(!frame_select_n) && !fall_now |-> $stable(result_out))
        else $error("result bit moved off a serial fall");
    frame_length_a: assert property (
        $rose(frame_select_n) |-> fall_cnt == 5'h10 || fall_cnt == 5'h08)
        else $error("frame closed with wrong fall count");
    equal_spacing_a: assert property (
        started && prev_sel && !frame_select_n |-> gap_cnt == GAP)
        else $error("frame starts not equally spaced");
    select_gap_a: assert property (
        $rose(frame_select_n) |-> frame_select_n[*8] ##1 frame_select_n[*8])
        else $error("select high too briefly between frames");

    full_frame_c: cover property ($rose(frame_select_n) && fall_cnt == 5'h10);
    burst_frame_c: cover property ($rose(frame_select_n) && fall_cnt == 5'h08);
    one_bit_c: cover property (result_oe && result_out);
endmodule // adc_link_props

// [bench/adc_serial_conversion_port_tb.sv]
// Testbench: wide and narrow converter ends, each with its own host.
// Assumes both hosts leave reset together and so frame in step.
`timescale 1ns/10ps
module adc_serial_conversion_port_tb;
    logic                i_sys_clk;
    logic                i_reset;
    logic                enable;      // Hosts run frames
    logic                power_down;  // Hosts send bursts
    logic [11:0]         code_a;      // Wide input code
    logic [9:0]          code_b;      // Narrow input code
    adc_link_pkg::word_t word_a;
    adc_link_pkg::word_t word_b;
    logic                wv_a;
    logic                busy_a;
    logic [11:0]         res_a;
    logic [9:0]          res_b;
    logic                rv_a;
    logic                hold_a;
    int                  bad_count = 0;
    int                  tests_run = 0;
    int                  nwv = 0;     // Word pulses seen
    int                  nrv = 0;     // Result pulses seen
    int                  falls_a = 0;
    int                  last_a = 0;  // Falls of last wide frame
    int                  falls_b = 0;
    int                  last_b = 0;
    logic                bit_at_fall; // Line just after the fifteenth fall
    logic [11:0]         codes [4] = '{12'h000, 12'hfff, 12'ha5a, 12'h5a5};

    adc_link_if link_a ();
    adc_link_if link_b ();

    adc_conv_host adc_conv_host_inst (.link(link_a), .i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_enable(enable), .i_power_down(power_down),
        .o_word(word_a), .o_word_valid(wv_a), .o_busy(busy_a));
    adc_conv_device adc_conv_device_inst (.link(link_a), .i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_analog_code(code_a), .o_result(res_a),
        .o_result_valid(rv_a), .o_sampler_hold(hold_a));
    adc_conv_host adc_conv_host_narrow_inst (.link(link_b), .i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_enable(enable), .i_power_down(power_down),
        .o_word(word_b), .o_word_valid(), .o_busy());
    adc_conv_device #(.RESOLUTION(10)) adc_conv_device_narrow_inst (.link(link_b),
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_analog_code(code_b),
        .o_result(res_b), .o_result_valid(), .o_sampler_hold());
    adc_link_props adc_link_props_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .frame_select_n(link_a.frame_select_n), .serial_clk(link_a.serial_clk),
        .result_out(link_a.result_out), .result_oe(link_a.result_oe));

    // System clock, 20 ns
    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Waits for a host word, bounded; leaves us just past that edge
    task automatic wait_word;
        int n;
        n = 0;
        do
        begin
            @(posedge i_sys_clk);
            #2;
            n++;
        end
        while (wv_a !== 1'b1 && n < 400);
        if (n == 400)
            bad_count++;
    endtask

    // Pulse counts, sampled away from the launching edge
    always @(negedge i_sys_clk)
    begin
        nwv += (wv_a === 1'b1);
        nrv += (rv_a === 1'b1);
    end

    // Wire watch on serial falls, once the host flops have settled
    always
    begin
        @(negedge link_a.serial_clk);
        #1;
        if (!link_a.frame_select_n)
            falls_a++;
        else if (falls_a != 0)
        begin
            last_a = falls_a;
            falls_a = 0;
        end
        // sampler holds mid frame, tracks by the fifteenth fall
        if (falls_a == 12 && !power_down)
            check("sampler hold", hold_a, 1'b1);
        if (falls_a == 12)
            check("host busy", busy_a, 1'b1);
        if (falls_a == 15)
            bit_at_fall = link_a.result_line;
        if (falls_a == 15 && !power_down)
            check("sampler track", hold_a, 1'b0);
        if (!link_b.frame_select_n)
            falls_b++;
        else if (falls_b != 0)
        begin
            last_b = falls_b;
            falls_b = 0;
        end
        // narrow end fills the word with two zeros
        if ((falls_b == 14 || falls_b == 15) && !power_down)
            check("narrow trailing zero", link_b.result_line, 1'b0);
        // narrow end releases at the sixteenth fall
        if (falls_b == 16)
            check("narrow release", link_b.result_oe, 1'b0);
    end

    // Rising-edge capture view of the wide link
    always
    begin
        @(posedge link_a.serial_clk);
        #1;
        // second leading zero readable at first rise
        if (!link_a.frame_select_n && falls_a == 1)
            check("zero at first rise", link_a.result_line, 1'b0);
        // last bit still there at fifteenth rise
        if (!link_a.frame_select_n && falls_a == 15 && !power_down)
            check("last bit at rise", link_a.result_line, bit_at_fall);
    end

    // Hang guard, about twice the expected run
    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        end_of_test;
    end

    initial
    begin
        i_reset = 1'b1;
        enable = 1'b0;
        power_down = 1'b0;
        code_a = 12'h000;
        code_b = 10'h000;
        repeat (8) @(posedge i_sys_clk);
        #2;
        check("select in reset", link_a.frame_select_n, 1'b1);
        check("word in reset", {wv_a, busy_a, word_a}, 18'h00000);
        i_reset = 1'b0;
        @(posedge i_sys_clk);
        #2;
        enable = 1'b1;
        // Every code reaches both words, MSB first behind the header
        for (int i = 0; i < 4; i++)
        begin
            code_a = codes[i];
            code_b = codes[i][11:2];
            wait_word;
            wait_word;
            check("wide word", word_a, {4'h0, code_a});
            check("narrow word", word_b, {4'h0, code_b, 2'b00});
            check("wide result", res_a, code_a);
            check("narrow result", res_b, code_b);
        end
        check("wide frame falls", last_a, 16);
        check("narrow frame falls", last_b, 16);
        // Bursts cut the frame short: no word, no result
        power_down = 1'b1;
        repeat (200) @(posedge i_sys_clk);
        #2;
        nwv = 0;
        nrv = 0;
        repeat (320) @(posedge i_sys_clk);
        check("burst word pulses", nwv, 0);
        check("burst result pulses", nrv, 0);
        check("burst falls", last_a, 8);
        check("narrow burst falls", last_b, 8);
        // Full frames resume after an aborted one
        #2;
        power_down = 1'b0;
        code_a = 12'h3c6;
        code_b = 10'h2b9;
        wait_word;
        wait_word;
        check("wide word again", word_a, {4'h0, code_a});
        check("narrow word again", word_b, {4'h0, code_b, 2'b00});
        end_of_test;
    end
endmodule // adc_serial_conversion_port_tb
